// file: include/system_control_defines.svh
// timing counts, offsets, opcodes and field positions for the system control block
// Summary of operation
// - Frame tick at vsync start, every 175 lines
// - Each tick bumps counter, saturating at fifteen
// - Tick interrupt active while count non-zero, unmaskable
// - Reading the counter returns it and clears it
// - Tick during read is never lost or doubled
// - First opcode fetch after reset loads one
// - Low nibble opcode; high nibble only for port
// - Opcode 1 requests immediate whole-system reset
// - Disk interrupt routed to NMI, INT or neither
// - Opcodes 5/6 set/clear terminal count, clear at reset
// - Video floated, tone off, port zero at reset
// - Opcode B starts 3.75 kHz tone, C stops
// - Opcode F copies D7..D4 onto output pins
// - Colour strap swaps upper pins for red/blue video
// - Status reports each interrupt source in its bit
// - Maskable interrupt when any source bit active, disk only when routed to INT
// - Status bit 2 shows frame flyback instead
// - Printer, disk, serial interrupts active high
// - Shared interrupt active low, wired-AND by others
// - Keyboard and tick interrupts generated internally
// - Strap port shows pins sampled at reset
// - Strap pairs select wait states per region
// - Frame is 525 lines counted on line sync
// - Vsync low two lines, two lines into blanking
// - Flyback set through the 29 blanked lines
`ifndef SYSTEM_CONTROL_DEFINES_SVH
`define SYSTEM_CONTROL_DEFINES_SVH

`define CLK_HZ        20000000
`define TONE_HZ       3750
`define FRAME_LINES   10'h20D
`define BLANK_LINES   10'h01D
`define VSYNC_START   10'h002
`define VSYNC_LINES   10'h002
`define TICK_SPACING  10'h0AF
`define TICK_MAX      4'hF
`define TICKS_RESET   4'h0
`define PORT_RESET    4'h0
`define STRAP_SETTLE  2'h3

`define OFS_COMMAND   4'h0
`define OFS_STATUS    4'h4
`define OFS_STRAP     4'h8
`define OFS_TICKS     4'hC

`define OP_SYS_RESET  4'h1
`define OP_DISK_NMI   4'h2
`define OP_DISK_INT   4'h3
`define OP_DISK_OFF   4'h4
`define OP_TC_SET     4'h5
`define OP_TC_CLR     4'h6
`define OP_VID_DRIVE  4'h7
`define OP_VID_FLOAT  4'h8
`define OP_TONE_ON    4'hB
`define OP_TONE_OFF   4'hC
`define OP_PORT_LOAD  4'hF

`define ST_TICK       0
`define ST_KBD        1
`define ST_FLYBACK    2
`define ST_SER_B      3
`define ST_SER_A      4
`define ST_SHARED     5
`define ST_DISK       6
`define ST_PRN        7
`define STRAP_COLOUR  4

`endif

// file: include/system_control_pkg.sv
// types shared by the system control block
package system_control_pkg;
  typedef enum logic [1:0] {ROUTE_NONE, ROUTE_NMI, ROUTE_INT} irq_route_t;
endpackage

// file: logic/frame_timing.sv
// vertical frame timing: line count, vsync, flyback and frame ticks
`include "system_control_defines.svh"
`timescale 1ns/10ps
`default_nettype none
module frame_timing #(
  parameter logic [9:0] FRAME_LINES = `FRAME_LINES,
  parameter logic [9:0] BLANK_LINES = `BLANK_LINES,
  parameter logic [9:0] VS_START    = `VSYNC_START,
  parameter logic [9:0] VS_LINES    = `VSYNC_LINES,
  parameter logic [9:0] SPACING     = `TICK_SPACING
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic line_pulse_i,
  output var  logic vert_sync_n_o,
  output var  logic flyback_o,
  output var  logic tick_o
);
  logic [9:0] line_reg;
  logic [9:0] line_next;

  always_comb begin
    line_next = (line_reg == FRAME_LINES - 10'h001) ? 10'h000 : line_reg + 10'h001;
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      line_reg      <= 10'h000;
      vert_sync_n_o <= 1'b1;
      flyback_o     <= 1'b1;
    end else if (line_pulse_i) begin
      line_reg      <= line_next;
      vert_sync_n_o <= !(line_next >= VS_START && line_next < VS_START + VS_LINES);
      flyback_o     <= line_next < BLANK_LINES;
    end
  end

  // ticks are one clock wide and fall on line edges only
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      tick_o <= 1'b0;
    end else begin
      tick_o <= line_pulse_i && (line_next == VS_START || line_next == VS_START + SPACING ||
                line_next == VS_START + SPACING + SPACING);
    end
  end

  vsync_tick_a: assert property (
    @(posedge clk_i) disable iff (rst_i) $fell(vert_sync_n_o) |-> tick_o)
    else $error("vsync leading edge without frame tick");

  line_wrap_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    line_pulse_i && line_reg == FRAME_LINES - 10'h001 |=> line_reg == 10'h000)
    else $error("frame did not wrap after last line");
endmodule
`default_nettype wire

// file: logic/tone_gen.sv
// square wave tone from a divided enable pulse
`include "system_control_defines.svh"
`timescale 1ns/10ps
`default_nettype none
module tone_gen #(
  parameter int HALF_CYC = `CLK_HZ / (2 * `TONE_HZ)
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic enable_i,
  output var  logic tone_o
);
  logic [11:0] div_reg;
  logic        step;

  assign step = div_reg == 12'(HALF_CYC - 1);

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      div_reg <= 12'h000;
    end else begin
      div_reg <= step ? 12'h000 : div_reg + 12'h001;
    end
  end

  // idles low when off so the speaker carries no standing current
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      tone_o <= 1'b0;
    end else if (!enable_i) begin
      tone_o <= 1'b0;
    end else if (step) begin
      tone_o <= !tone_o;
    end
  end

  tone_off_a: assert property (
    @(posedge clk_i) disable iff (rst_i) !enable_i |=> !tone_o)
    else $error("tone running while disabled");
endmodule
`default_nettype wire

// file: logic/system_control_status_irq.sv
// system command, interrupt status, strap and frame tick registers on avalon-mm
//
// Implementation choices: register access over Avalon-MM and the register addresses.
`include "system_control_defines.svh"
`timescale 1ns/10ps
`default_nettype none
module system_control_status_irq (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic [3:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output var  logic [31:0] avs_readdata_o,
  output var  logic        avs_waitrequest_o,
  input  wire logic        opcode_fetch_cycle_i,
  input  wire logic        keyboard_irq_i,
  input  wire logic        red_video_out_i,
  input  wire logic        blue_video_out_i,
  input  wire logic        line_sync_n_i,
  input  wire logic        printer_irq_i,
  input  wire logic        disk_irq_i,
  input  wire logic        serial_a_irq_i,
  input  wire logic        serial_b_irq_i,
  input  wire logic        shared_wired_irq_n_i,
  input  wire logic        rom_select_pin_i,
  input  wire logic [6:0]  upper_address_straps_i,
  output var  logic        cpu_int_n_o,
  output var  logic        cpu_nmi_n_o,
  output var  logic        system_reset_o,
  output var  logic        fdc_terminal_count_o,
  output var  logic        video_oe_o,
  output var  logic        bleeper_o,
  output var  logic [3:0]  general_output_pins_o,
  output var  logic [3:0]  general_output_oe_o,
  output var  logic        vert_sync_n_o,
  output var  logic [3:0]  fetch_waits_o,
  output var  logic [3:0]  other_waits_o
);
  localparam int PIN_N = 14;
  // active-low pins reset to their idle high level, so no false edge follows reset
  localparam logic [PIN_N-1:0] PIN_IDLE = 14'h0021;

  logic [PIN_N-1:0] pin_raw;
  logic [PIN_N-1:0] pin_meta;
  logic [PIN_N-1:0] pin_sync;

  logic        line_sync_n_s;
  logic        line_sync_n_d;
  logic        printer_irq_s;
  logic        disk_irq_s;
  logic        serial_a_irq_s;
  logic        serial_b_irq_s;
  logic        shared_wired_irq_n_s;
  logic [7:0]  strap_pins_s;

  logic        wait_reg;
  logic        req;
  logic        rd_take;
  logic        wr_done;
  logic [3:0]  opcode;

  system_control_pkg::irq_route_t route_reg;
  logic        tone_on_reg;
  logic        video_drive_reg;
  logic [3:0]  port_reg;
  logic [3:0]  ticks_reg;
  logic        first_fetch_reg;
  logic [7:0]  strap_reg;
  logic        strap_done_reg;
  logic [1:0]  settle_reg;

  logic        frame_tick;
  logic        flyback;
  logic [7:0]  status_now;
  logic        int_any;
  logic        ticks_clear;

  // every pin input crosses in through two flops before use
  assign pin_raw = {rom_select_pin_i, upper_address_straps_i, line_sync_n_i, printer_irq_i,
                    disk_irq_i, serial_a_irq_i, serial_b_irq_i, shared_wired_irq_n_i};

  generate
    for (genvar i = 0; i < PIN_N; i++) begin : g_sync
      always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
          pin_meta[i] <= PIN_IDLE[i];
          pin_sync[i] <= PIN_IDLE[i];
        end else begin
          pin_meta[i] <= pin_raw[i];
          pin_sync[i] <= pin_meta[i];
        end
      end
    end
  endgenerate

  assign shared_wired_irq_n_s = pin_sync[0];
  assign serial_b_irq_s       = pin_sync[1];
  assign serial_a_irq_s       = pin_sync[2];
  assign disk_irq_s           = pin_sync[3];
  assign printer_irq_s        = pin_sync[4];
  assign line_sync_n_s        = pin_sync[5];
  // strap bit 0 is the rom select pin, bits 7..1 the upper address pins
  assign strap_pins_s         = {pin_sync[12:6], pin_sync[13]};

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      line_sync_n_d <= 1'b1;
    end else begin
      line_sync_n_d <= line_sync_n_s;
    end
  end

  frame_timing u_frame (
    .clk_i         (clk_i),
    .rst_i         (rst_i),
    .line_pulse_i  (line_sync_n_d && !line_sync_n_s),
    .vert_sync_n_o (vert_sync_n_o),
    .flyback_o     (flyback),
    .tick_o        (frame_tick)
  );

  tone_gen u_tone (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .enable_i (tone_on_reg),
    .tone_o   (bleeper_o)
  );

  // bus slave: one wait cycle, then the access completes
  assign req     = avs_read_i || avs_write_i;
  assign rd_take = avs_read_i && wait_reg;
  assign wr_done = avs_write_i && !wait_reg && avs_byteenable_i[0]
                   && avs_address_i == `OFS_COMMAND;
  assign opcode  = avs_writedata_i[3:0];

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wait_reg <= 1'b1;
    end else begin
      wait_reg <= !(req && wait_reg);
    end
  end

  assign avs_waitrequest_o = wait_reg;

  always_comb begin
    status_now                = 8'h00;
    status_now[`ST_TICK]      = ticks_reg != 4'h0;
    status_now[`ST_KBD]       = keyboard_irq_i;
    status_now[`ST_FLYBACK]   = flyback;
    status_now[`ST_SER_B]     = serial_b_irq_s;
    status_now[`ST_SER_A]     = serial_a_irq_s;
    status_now[`ST_SHARED]    = !shared_wired_irq_n_s;
    status_now[`ST_DISK]      = disk_irq_s;
    status_now[`ST_PRN]       = printer_irq_s;
  end

  // flyback is not an interrupt, disk only counts when routed to int
  assign int_any = status_now[`ST_TICK] || status_now[`ST_KBD] || status_now[`ST_SER_B]
                   || status_now[`ST_SER_A] || status_now[`ST_SHARED] || status_now[`ST_PRN]
                   || (status_now[`ST_DISK] && route_reg == system_control_pkg::ROUTE_INT);

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cpu_int_n_o <= 1'b1;
      cpu_nmi_n_o <= 1'b1;
    end else begin
      cpu_int_n_o <= !int_any;
      cpu_nmi_n_o <= !(disk_irq_s && route_reg == system_control_pkg::ROUTE_NMI);
    end
  end

  // read data is captured on the first request cycle and held for the ack
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      avs_readdata_o <= 32'h0000_0000;
    end else if (rd_take) begin
      unique case (avs_address_i)
        `OFS_STATUS: avs_readdata_o <= {24'h00_0000, status_now};
        `OFS_STRAP:  avs_readdata_o <= {24'h00_0000, strap_reg};
        `OFS_TICKS:  avs_readdata_o <= {28'h000_0000, ticks_reg};
        default:     avs_readdata_o <= 32'h0000_0000;
      endcase
    end
  end

  // clear at the capture edge so the value returned is exactly the value dropped
  assign ticks_clear = rd_take && avs_address_i == `OFS_TICKS && avs_byteenable_i[0];

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ticks_reg       <= `TICKS_RESET;
      first_fetch_reg <= 1'b0;
    end else if (opcode_fetch_cycle_i && !first_fetch_reg) begin
      ticks_reg       <= 4'h1;
      first_fetch_reg <= 1'b1;
    end else if (ticks_clear) begin
      // a tick on the clearing edge becomes the new count of one
      ticks_reg <= frame_tick ? 4'h1 : 4'h0;
    end else if (frame_tick && ticks_reg != `TICK_MAX) begin
      ticks_reg <= ticks_reg + 4'h1;
    end
  end

  // command opcodes; unlisted codes fall through and change nothing
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      route_reg <= system_control_pkg::ROUTE_NONE;
    end else if (wr_done) begin
      unique case (opcode)
        `OP_DISK_NMI: route_reg <= system_control_pkg::ROUTE_NMI;
        `OP_DISK_INT: route_reg <= system_control_pkg::ROUTE_INT;
        `OP_DISK_OFF: route_reg <= system_control_pkg::ROUTE_NONE;
        default:      route_reg <= route_reg;
      endcase
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      fdc_terminal_count_o <= 1'b0;
    end else if (wr_done && opcode == `OP_TC_SET) begin
      fdc_terminal_count_o <= 1'b1;
    end else if (wr_done && opcode == `OP_TC_CLR) begin
      fdc_terminal_count_o <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      video_drive_reg <= 1'b0;
    end else if (wr_done && opcode == `OP_VID_DRIVE) begin
      video_drive_reg <= 1'b1;
    end else if (wr_done && opcode == `OP_VID_FLOAT) begin
      video_drive_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      tone_on_reg <= 1'b0;
    end else if (wr_done && opcode == `OP_TONE_ON) begin
      tone_on_reg <= 1'b1;
    end else if (wr_done && opcode == `OP_TONE_OFF) begin
      tone_on_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      port_reg <= `PORT_RESET;
    end else if (wr_done && opcode == `OP_PORT_LOAD) begin
      port_reg <= avs_writedata_i[7:4];
    end
  end

  // the reset request is a single pulse; the system reset logic stretches it
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      system_reset_o <= 1'b0;
    end else begin
      system_reset_o <= wr_done && opcode == `OP_SYS_RESET;
    end
  end

  // straps settle through the synchroniser, then are frozen until next reset
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      settle_reg     <= 2'h0;
      strap_done_reg <= 1'b0;
      strap_reg      <= 8'h00;
    end else if (!strap_done_reg) begin
      if (settle_reg == `STRAP_SETTLE) begin
        strap_reg      <= strap_pins_s;
        strap_done_reg <= 1'b1;
      end else begin
        settle_reg <= settle_reg + 2'h1;
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      general_output_pins_o <= `PORT_RESET;
      general_output_oe_o   <= 4'h0;
      video_oe_o            <= 1'b0;
    end else begin
      video_oe_o <= video_drive_reg;
      if (strap_reg[`STRAP_COLOUR]) begin
        // floated video shows low, so the port still reads zero after reset
        general_output_pins_o <= {red_video_out_i && video_drive_reg,
                                  blue_video_out_i && video_drive_reg, port_reg[1:0]};
        general_output_oe_o   <= {video_drive_reg, video_drive_reg, 2'h3};
      end else begin
        general_output_pins_o <= port_reg;
        general_output_oe_o   <= 4'hF;
      end
    end
  end

  // wait-state decode per region: bit 1 picks two on fetch; elsewhere each set bit of the pair adds one
  generate
    for (genvar r = 0; r < 2; r++) begin : g_waits
      always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
          fetch_waits_o[2*r +: 2] <= 2'h1;
          other_waits_o[2*r +: 2] <= 2'h0;
        end else begin
          fetch_waits_o[2*r +: 2] <= strap_reg[2*r+1] ? 2'h2 : 2'h1;
          other_waits_o[2*r +: 2] <= strap_reg[2*r+1:2*r] == 2'h3 ? 2'h2 :
                                     strap_reg[2*r+1:2*r] == 2'h0 ? 2'h0 : 2'h1;
        end
      end
    end
  endgenerate

  tick_sat_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    ticks_reg == `TICK_MAX && !ticks_clear && first_fetch_reg |=> ticks_reg == `TICK_MAX)
    else $error("tick counter left fifteen without a read");

  tick_irq_a: assert property (
    @(posedge clk_i) disable iff (rst_i) ticks_reg != 4'h0 |=> !cpu_int_n_o)
    else $error("pending ticks did not raise the interrupt");

  read_clear_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    ticks_clear && !frame_tick && first_fetch_reg ##1 !avs_waitrequest_o
    |-> ticks_reg == 4'h0 && avs_readdata_o[3:0] == $past(ticks_reg))
    else $error("tick read did not return and clear the count");

  read_tick_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    ticks_clear && frame_tick && first_fetch_reg |=> ticks_reg == 4'h1)
    else $error("tick during read was lost");

  first_fetch_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    opcode_fetch_cycle_i && !first_fetch_reg |=> ticks_reg == 4'h1 && first_fetch_reg)
    else $error("first fetch did not load one");

  tc_cmd_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    wr_done && opcode == `OP_TC_SET |=> fdc_terminal_count_o)
    else $error("terminal count did not follow set command");

  tc_hold_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    fdc_terminal_count_o && !(wr_done && opcode == `OP_TC_CLR) |=> fdc_terminal_count_o)
    else $error("terminal count dropped without clear command");

  disk_nmi_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    disk_irq_s && route_reg == system_control_pkg::ROUTE_NMI |=> !cpu_nmi_n_o)
    else $error("routed disk interrupt missed nmi");

  port_load_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    wr_done && opcode == `OP_PORT_LOAD && !strap_reg[`STRAP_COLOUR]
    |-> ##2 general_output_pins_o == $past(avs_writedata_i[7:4], 2))
    else $error("output port did not take data bits 7..4");
endmodule
`default_nettype wire

// file: tb/far_side_model.sv
// far side model: line sync source, companion interrupt pins and wired-and line
`timescale 1ns/10ps
`default_nettype none
module far_side_model (
  input  wire logic       clk_i,
  input  wire logic [3:0] src_i,
  input  wire logic [1:0] pull_low_i,
  output var  logic       line_sync_n_o,
  output var  logic       printer_irq_o,
  output var  logic       disk_irq_o,
  output var  logic       serial_a_irq_o,
  output var  logic       serial_b_irq_o,
  output var  logic       shared_n_o
);
  assign printer_irq_o = src_i[0];
  assign disk_irq_o = src_i[1];
  assign serial_a_irq_o = src_i[2];
  assign serial_b_irq_o = src_i[3];
  // pull-up wins unless any device on the line pulls it down
  assign shared_n_o = ~|pull_low_i;
  initial line_sync_n_o = 1'b1;
  // eight-cycle lines keep a whole frame short; idle high between calls
  task automatic lines(input int n);
    repeat (n) begin
      @(posedge clk_i);
      line_sync_n_o <= 1'b0;
      repeat (2) @(posedge clk_i);
      line_sync_n_o <= 1'b1;
      repeat (5) @(posedge clk_i);
    end
  endtask
endmodule
`default_nettype wire

// file: tb/test_system_control_status_irq.sv
// self-checking bench for the system control, status and tick block
`timescale 1ns/10ps
`default_nettype none
module test_system_control_status_irq;
  localparam int HALF = 20000000 / (2 * 3750);
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        avs_read_i = 1'b0;
  logic        avs_write_i = 1'b0;
  logic        opcode_fetch_cycle_i = 1'b0;
  logic        keyboard_irq_i = 1'b0;
  logic        red_video_out_i = 1'b0;
  logic        blue_video_out_i = 1'b0;
  logic        rom_select_pin_i = 1'b0;
  logic [3:0]  avs_address_i = 4'h0;
  logic [3:0]  avs_byteenable_i = 4'hF;
  logic [31:0] avs_writedata_i = 32'h0;
  logic [6:0]  upper_address_straps_i = 7'h00;
  logic [3:0]  src = 4'h0;
  logic [1:0]  pull_low = 2'h0;
  logic [3:0]  nops [5] = '{4'h0, 4'h9, 4'hA, 4'hD, 4'hE};
  int          error_cnt = 0;
  int          n_compared = 0;
  wire logic [31:0] avs_readdata_o;
  wire logic avs_waitrequest_o, line_sync_n_i, printer_irq_i, disk_irq_i, serial_a_irq_i;
  wire logic serial_b_irq_i, shared_wired_irq_n_i, cpu_int_n_o, cpu_nmi_n_o, system_reset_o;
  wire logic fdc_terminal_count_o, video_oe_o, bleeper_o, vert_sync_n_o;
  wire logic [3:0] general_output_pins_o, general_output_oe_o, fetch_waits_o, other_waits_o;
  system_control_status_irq dut (.clk_i, .rst_i, .avs_address_i, .avs_read_i, .avs_write_i,
    .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o,
    .opcode_fetch_cycle_i, .keyboard_irq_i, .red_video_out_i, .blue_video_out_i,
    .line_sync_n_i, .printer_irq_i, .disk_irq_i, .serial_a_irq_i, .serial_b_irq_i,
    .shared_wired_irq_n_i, .rom_select_pin_i, .upper_address_straps_i, .cpu_int_n_o,
    .cpu_nmi_n_o, .system_reset_o, .fdc_terminal_count_o, .video_oe_o, .bleeper_o,
    .general_output_pins_o, .general_output_oe_o, .vert_sync_n_o, .fetch_waits_o,
    .other_waits_o);
  far_side_model far (.clk_i, .src_i(src), .pull_low_i(pull_low),
    .line_sync_n_o(line_sync_n_i), .printer_irq_o(printer_irq_i), .disk_irq_o(disk_irq_i),
    .serial_a_irq_o(serial_a_irq_i), .serial_b_irq_o(serial_b_irq_i),
    .shared_n_o(shared_wired_irq_n_i));
  always #25 clk_i = ~clk_i;
  task automatic wrap_up;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  // one avalon access; held until waitrequest is sampled low at a rising edge
  task automatic acc(input logic [3:0] a, input logic w, input logic [7:0] d,
                     output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    avs_address_i <= a;
    avs_write_i <= w;
    avs_read_i <= !w;
    avs_writedata_i <= {24'h0, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0 && n < 20);
    if (n >= 20) chk(32'h1, 32'h0);
    if (n >= 20) wrap_up();
    q = avs_readdata_o;
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
  endtask
  task automatic tone_wait(input logic lvl, output int n);
    n = 0;
    while (bleeper_o !== lvl) begin
      @(negedge clk_i);
      n++;
      if (n > 2 * HALF) chk(32'h1, 32'h0);
      if (n > 2 * HALF) wrap_up();
    end
  endtask
  function automatic logic [7:0] waits(input logic [3:0] j);
    return {2'(1 + j[3]), 2'(1 + j[1]), 2'({1'b0, j[3]} + j[2]), 2'({1'b0, j[1]} + j[0])};
  endfunction
  initial begin
    logic [31:0] q;
    logic [7:0]  r;
    logic [7:0]  st;
    logic [7:0]  e;
    logic [1:0]  ir;
    int          nf;
    int          nv;
    void'($urandom(22158));
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    cyc(3);
    @(posedge clk_i);
    opcode_fetch_cycle_i <= 1'b1;
    @(posedge clk_i);
    opcode_fetch_cycle_i <= 1'b0;
    acc(4'hC, 1'b0, 8'h00, q);
    chk(q, 32'h1);
    acc(4'hC, 1'b0, 8'h00, q);
    chk(q, 32'h0);
    acc(4'h2, 1'b0, 8'h00, q);
    chk(q, 32'h0);
    nf = 0;
    nv = 0;
    repeat (525) begin
      far.lines(1);
      acc(4'h4, 1'b0, 8'h00, q);
      nf += int'(q[2]);
      nv += int'(!vert_sync_n_o);
    end
    chk(nf, 29);
    chk(nv, 2);
    acc(4'hC, 1'b0, 8'h00, q);
    chk(q, 32'h3);
    for (int i = 0; i < 9; i++) begin
      r = (i < 3) ? 8'h02 : 8'($urandom);
      acc(4'h0, 1'b1, {4'($urandom), 4'h2 + 4'(i % 3)}, q);
      @(posedge clk_i);
      src <= r[3:0];
      pull_low <= r[5:4];
      keyboard_irq_i <= r[6];
      cyc(6);
      acc(4'h4, 1'b0, 8'h00, q);
      e = {r[0], r[1], |r[5:4], r[2], r[3], 1'b0, r[6], 1'b0};
      ir = {~(|{e[7], e[5:3], e[1]} | (r[1] && i % 3 == 1)), ~(r[1] && i % 3 == 0)};
      chk(q & 32'hFB, {24'h0, e});
      chk({cpu_int_n_o, cpu_nmi_n_o}, ir);
    end
    @(posedge clk_i);
    src <= 4'h0;
    pull_low <= 2'h0;
    keyboard_irq_i <= 1'b0;
    acc(4'h0, 1'b1, 8'hA5, q);
    acc(4'h0, 1'b1, 8'hC7, q);
    acc(4'h0, 1'b1, 8'h9F, q);
    for (int k = 0; k < 5; k++) acc(4'h0, 1'b1, {4'($urandom), nops[k]}, q);
    cyc(3);
    chk({fdc_terminal_count_o, video_oe_o, general_output_pins_o}, 6'h39);
    acc(4'h0, 1'b1, 8'h06, q);
    acc(4'h0, 1'b1, 8'h08, q);
    cyc(3);
    chk({fdc_terminal_count_o, video_oe_o}, 2'b00);
    acc(4'h0, 1'b1, 8'h0B, q);
    tone_wait(1'b1, nf);
    tone_wait(1'b0, nf);
    chk(nf, HALF);
    acc(4'h0, 1'b1, 8'h0C, q);
    cyc(HALF + 10);
    chk(bleeper_o, 1'b0);
    acc(4'h0, 1'b1, 8'h71, q);
    nf = 0;
    repeat (6) begin
      @(negedge clk_i);
      nf += int'(system_reset_o);
    end
    chk(nf, 1);
    far.lines(175 * 17);
    acc(4'h4, 1'b0, 8'h00, q);
    chk({q[0], cpu_int_n_o}, 2'b10);
    acc(4'hC, 1'b0, 8'h00, q);
    chk(q, 32'hF);
    cyc(3);
    chk(cpu_int_n_o, 1'b1);
    // second and third reset: one strap set without, one with the colour strap
    for (int c = 0; c < 2; c++) begin
      st = 8'($urandom);
      st[4] = c[0];
      @(posedge clk_i);
      rst_i <= 1'b1;
      rom_select_pin_i <= st[0];
      upper_address_straps_i <= st[7:1];
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      cyc(10);
      chk({fdc_terminal_count_o, video_oe_o, bleeper_o, general_output_pins_o}, 0);
      @(posedge clk_i);
      rom_select_pin_i <= ~st[0];
      upper_address_straps_i <= ~st[7:1];
      acc(4'h8, 1'b0, 8'h00, q);
      chk(q, {24'h0, st});
      chk({fetch_waits_o, other_waits_o}, waits(st[3:0]));
      r = 8'($urandom);
      red_video_out_i <= r[1];
      blue_video_out_i <= r[0];
      acc(4'h0, 1'b1, 8'h07, q);
      acc(4'h0, 1'b1, {r[7:4], 4'hF}, q);
      cyc(4);
      e = {c ? {r[1:0], r[5:4]} : r[7:4], 4'hF};
      chk({general_output_pins_o, general_output_oe_o}, e);
    end
    wrap_up();
  end
endmodule
`default_nettype wire
